// *** logic/debug_link_pkg.sv ***
// constants shared by the breakpoint, time tag and debug serial link registers
package debug_link_pkg;
	// register byte addresses
	localparam logic [31:0] TIME_TAG_ADDR = 32'h9000_0008;
	localparam logic [31:0] BP_ONE_ADDR_ADDR = 32'h9000_0010;
	localparam logic [31:0] BP_ONE_MASK_ADDR = 32'h9000_0014;
	localparam logic [31:0] BP_TWO_ADDR_ADDR = 32'h9000_0018;
	localparam logic [31:0] BP_TWO_MASK_ADDR = 32'h9000_001C;
	localparam logic [31:0] LINK_STATUS_ADDR = 32'h8000_00C4;
	localparam logic [31:0] LINK_CONTROL_ADDR = 32'h8000_00C8;
	localparam logic [31:0] LINK_SCALER_ADDR = 32'h8000_00CC;
	localparam logic [31:0] IRQ_STATUS_ADDR = 32'h8000_00D0;
	localparam logic [31:0] IRQ_MASK_ADDR = 32'h8000_00D4;
	// field layout
	localparam int TIME_TAG_WIDTH = 30;
	localparam int BP_ADDR_LSB = 2;
	localparam int EXEC_EN_BIT = 0;
	localparam int LOAD_EN_BIT = 1;
	localparam int WRITE_EN_BIT = 0;
	localparam int FRAMING_BIT = 6;
	localparam int OVERRUN_BIT = 4;
	localparam int TX_HOLD_EMPTY_BIT = 2;
	localparam int TX_SHIFT_EMPTY_BIT = 1;
	localparam int RX_READY_BIT = 0;
	localparam int LOCKED_BIT = 1;
	localparam int LINK_ENABLE_BIT = 0;
	localparam int RELOAD_WIDTH = 18;
	// interrupt status and mask layout
	localparam int IRQ_WIDTH = 4;
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_FRAMING_BIT = 1;
	localparam int IRQ_OVERRUN_BIT = 2;
	localparam int IRQ_BREAK_BIT = 3;
	// reset values
	localparam logic [TIME_TAG_WIDTH-1:0] TIME_TAG_RESET = 30'h0000_0000;
	localparam logic [RELOAD_WIDTH-1:0] RELOAD_RESET = 18'h3_FFFF;
	localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 4'h0;
	// timing: sub-bit ticks per serial bit and the mid-bit point
	localparam logic [2:0] TICKS_PER_BIT_LAST = 3'h7;
	localparam logic [2:0] HALF_BIT_LAST = 3'h3;
	localparam int TICK_SHIFT = 3;
	localparam logic [2:0] LAST_DATA_BIT = 3'h7;
	typedef enum logic [3:0] {
		LINE_IDLE = 4'h1,
		LINE_START = 4'h2,
		LINE_DATA = 4'h4,
		LINE_STOP = 4'h8
	} line_state_t;
endpackage : debug_link_pkg

// *** logic/debug_breakpoint_uart_regs.sv ***
// breakpoints, time tag counter and debug serial link with its registers
//
// What this block does
// R1 - time tag counter in bits 29..0, read/write, resets to zero, upper bits zero
// R2 - time tag advances every clock while processor is not in debug mode
// R3 - breakpoint address holds word address bits 31..2; low two bits not stored
// R4 - address register bit 0 enables break on executed instruction at matching address
// R5 - execute enable is write-only, reads zero, resets zero; bit 1 reads zero
// R6 - mask register holds read/write address mask in bits 31..2
// R7 - match when all mask-selected bits equal; qualifies execute, load or write
// R8 - mask bit 1 enables break on bus load, read/write, resets zero
// R9 - mask bit 0 enables break on bus write, read/write, resets zero
// R10 - exactly two independent breakpoints with identical address and mask layouts
// R11 - with break-on-breakpoint enabled, any hit forces processor into debug mode
// R12 - status bit 6 set on receive framing error; resets zero, software writable
// R13 - status bit 4 set when characters lost to overrun; resets zero, writable
// R14 - status bit 2 transmit holding empty, bit 1 shifter empty; both reset one
// R15 - status bit 0 shows a received character waiting; resets zero
// R16 - control bit 1 set by hardware once baud rate is locked; resets zero
// R17 - control bit 0 enables receiver and transmitter together; resets zero
// R18 - scaler reload in bits 15..0 extended by 17..16; upper bits read zero
// R19 - bit rate is clock over eight times reload plus one
`timescale 1ns/1ps
module debug_breakpoint_uart_regs
	import debug_link_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [31:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [31:0] reg_rdata_out,
	input wire logic debug_mode_in,
	input wire logic break_on_hw_breakpoint_in,
	input wire logic exec_valid_in,
	input wire logic [31:0] exec_addr_in,
	input wire logic bus_load_in,
	input wire logic bus_write_in,
	input wire logic [31:0] bus_addr_in,
	output logic breakpoint_hit_out,
	output logic debug_break_out,
	output logic [TIME_TAG_WIDTH-1:0] time_tag_out,
	input wire logic serial_rx_in,
	output logic serial_tx_out,
	output logic [7:0] rx_data_out,
	output logic rx_data_ready_out,
	input wire logic rx_take_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_load_in,
	output logic tx_holding_empty_out,
	output logic irq_out
);
	localparam int BP_COUNT = 2;
	localparam int ADDR_BITS = 32 - BP_ADDR_LSB;
	localparam int MEASURE_WIDTH = RELOAD_WIDTH + TICK_SHIFT + 1;

	// decode
	wire wr_time = reg_write_in && reg_addr_in == TIME_TAG_ADDR;
	wire wr_status = reg_write_in && reg_addr_in == LINK_STATUS_ADDR;
	wire wr_control = reg_write_in && reg_addr_in == LINK_CONTROL_ADDR;
	wire wr_scaler = reg_write_in && reg_addr_in == LINK_SCALER_ADDR;
	wire wr_irq_status = reg_write_in && reg_addr_in == IRQ_STATUS_ADDR;
	wire wr_irq_mask = reg_write_in && reg_addr_in == IRQ_MASK_ADDR;
	logic [BP_COUNT-1:0] wr_bp_addr;
	logic [BP_COUNT-1:0] wr_bp_mask;
	assign wr_bp_addr[0] = reg_write_in && reg_addr_in == BP_ONE_ADDR_ADDR;
	assign wr_bp_addr[1] = reg_write_in && reg_addr_in == BP_TWO_ADDR_ADDR;
	assign wr_bp_mask[0] = reg_write_in && reg_addr_in == BP_ONE_MASK_ADDR;
	assign wr_bp_mask[1] = reg_write_in && reg_addr_in == BP_TWO_MASK_ADDR;

	// time tag
	logic [TIME_TAG_WIDTH-1:0] time_tag;
	wire [TIME_TAG_WIDTH-1:0] next_time_tag = wr_time ? reg_wdata_in[TIME_TAG_WIDTH-1:0]
		: debug_mode_in ? time_tag : time_tag + 1'b1; // R2
	always_ff @(posedge clock_in) begin
		if (reset_in) time_tag <= TIME_TAG_RESET; // R1
		else time_tag <= next_time_tag;
	end
	assign time_tag_out = time_tag;

	// breakpoints
	logic [ADDR_BITS-1:0] bp_addr [BP_COUNT]; // R3
	logic [ADDR_BITS-1:0] bp_mask [BP_COUNT]; // R6
	logic [BP_COUNT-1:0] bp_exec_en;
	logic [BP_COUNT-1:0] bp_load_en;
	logic [BP_COUNT-1:0] bp_write_en;
	logic [BP_COUNT-1:0] bp_hit;
	genvar g;
	generate
		for (g = 0; g < BP_COUNT; g++) begin : gen_bp // R10
			wire exec_match = ((exec_addr_in[31:BP_ADDR_LSB] ^ bp_addr[g]) & bp_mask[g]) == '0;
			wire bus_match = ((bus_addr_in[31:BP_ADDR_LSB] ^ bp_addr[g]) & bp_mask[g]) == '0;
			assign bp_hit[g] = (exec_valid_in && bp_exec_en[g] && exec_match) // R4 R7
				|| (bus_load_in && bp_load_en[g] && bus_match) // R8 R7
				|| (bus_write_in && bp_write_en[g] && bus_match); // R9 R7
			always_ff @(posedge clock_in) begin
				if (reset_in) begin
					bp_addr[g] <= '0;
					bp_exec_en[g] <= 1'b0; // R5
				end else if (wr_bp_addr[g]) begin
					bp_addr[g] <= reg_wdata_in[31:BP_ADDR_LSB];
					bp_exec_en[g] <= reg_wdata_in[EXEC_EN_BIT]; // R5
				end
			end
			always_ff @(posedge clock_in) begin
				if (reset_in) begin
					bp_mask[g] <= '0;
					bp_load_en[g] <= 1'b0;
					bp_write_en[g] <= 1'b0;
				end else if (wr_bp_mask[g]) begin
					bp_mask[g] <= reg_wdata_in[31:BP_ADDR_LSB];
					bp_load_en[g] <= reg_wdata_in[LOAD_EN_BIT]; // R8
					bp_write_en[g] <= reg_wdata_in[WRITE_EN_BIT]; // R9
				end
			end
		end
	endgenerate
	wire any_hit = |bp_hit;
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			breakpoint_hit_out <= 1'b0;
			debug_break_out <= 1'b0;
		end else begin
			breakpoint_hit_out <= any_hit;
			debug_break_out <= any_hit && break_on_hw_breakpoint_in; // R11
		end
	end

	// control and scaler
	logic link_enable;
	logic baud_locked;
	logic [RELOAD_WIDTH-1:0] reload_value;
	logic [RELOAD_WIDTH-1:0] scaler;
	logic measure_done;
	logic [RELOAD_WIDTH-1:0] measured_reload;
	always_ff @(posedge clock_in) begin
		if (reset_in) link_enable <= 1'b0; // R17
		else if (wr_control) link_enable <= reg_wdata_in[LINK_ENABLE_BIT]; // R17
	end
	// lock is hardware-owned; dropping the enable restarts the search
	always_ff @(posedge clock_in) begin
		if (reset_in || !link_enable) baud_locked <= 1'b0; // R16
		else if (measure_done) baud_locked <= 1'b1; // R16
	end
	always_ff @(posedge clock_in) begin
		if (reset_in) reload_value <= RELOAD_RESET; // R18
		else if (wr_scaler) reload_value <= reg_wdata_in[RELOAD_WIDTH-1:0]; // R18
		else if (measure_done) reload_value <= measured_reload; // R19
	end
	// one tick every reload+1 clocks: eight ticks make one bit
	wire tick = scaler == '0; // R19
	// restart on a new rate, else a stale count of up to 2^18 clocks delays the first tick
	always_ff @(posedge clock_in) begin
		if (reset_in || !link_enable || wr_scaler || measure_done) scaler <= '0; // R19
		else if (tick) scaler <= reload_value; // R19
		else scaler <= scaler - 1'b1;
	end

	// receive line sync
	logic rx_meta;
	logic rx_line;
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			rx_meta <= 1'b1;
			rx_line <= 1'b1;
		end else begin
			rx_meta <= serial_rx_in;
			rx_line <= rx_meta;
		end
	end

	// baud search: the host sends a sync character whose first low pulse is one bit long
	logic [MEASURE_WIDTH-1:0] low_count;
	logic measuring;
	wire measure_limit = &low_count;
	wire [MEASURE_WIDTH-1:0] bit_ticks = low_count >> TICK_SHIFT;
	assign measured_reload = bit_ticks[RELOAD_WIDTH-1:0] - 1'b1;
	assign measure_done = measuring && rx_line && bit_ticks != '0 && link_enable && !baud_locked;
	always_ff @(posedge clock_in) begin
		if (reset_in || baud_locked || !link_enable) begin
			measuring <= 1'b0;
			low_count <= '0;
		end else if (!rx_line) begin
			measuring <= 1'b1;
			if (!measure_limit) low_count <= low_count + 1'b1;
		end else begin
			measuring <= 1'b0;
			low_count <= '0;
		end
	end

	// receiver
	line_state_t rx_state;
	logic [2:0] rx_sub;
	logic [2:0] rx_bit;
	logic [7:0] rx_shift;
	logic rx_ready;
	logic framing_flag;
	logic overrun_flag;
	wire rx_run = link_enable && baud_locked; // R17
	wire rx_sample_data = rx_state == LINE_DATA && tick && rx_sub == TICKS_PER_BIT_LAST;
	wire rx_stop_point = rx_state == LINE_STOP && tick && rx_sub == TICKS_PER_BIT_LAST;
	wire rx_deliver = rx_stop_point && rx_line;
	wire rx_bad_stop = rx_stop_point && !rx_line;
	always_ff @(posedge clock_in) begin
		if (reset_in || !rx_run) begin
			rx_state <= LINE_IDLE;
			rx_sub <= '0;
			rx_bit <= '0;
			rx_shift <= '0;
		end else begin
			unique case (rx_state)
				LINE_IDLE: begin
					rx_sub <= '0;
					if (!rx_line) rx_state <= LINE_START;
				end
				LINE_START: if (tick) begin
					rx_sub <= rx_sub + 1'b1;
					if (rx_sub == HALF_BIT_LAST) begin
						// glitch shorter than half a bit is ignored
						rx_state <= rx_line ? LINE_IDLE : LINE_DATA;
						rx_sub <= '0;
						rx_bit <= '0;
					end
				end
				LINE_DATA: if (tick) begin
					rx_sub <= rx_sub + 1'b1;
					if (rx_sub == TICKS_PER_BIT_LAST) begin
						rx_shift <= {rx_line, rx_shift[7:1]};
						rx_bit <= rx_bit + 1'b1;
						if (rx_bit == LAST_DATA_BIT) rx_state <= LINE_STOP;
					end
				end
				LINE_STOP: if (tick) begin
					rx_sub <= rx_sub + 1'b1;
					if (rx_sub == TICKS_PER_BIT_LAST) rx_state <= LINE_IDLE;
				end
			endcase
		end
	end
	wire rx_lost = rx_deliver && rx_ready && !rx_take_in;
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			rx_ready <= 1'b0; // R15
			rx_data_out <= '0;
		end else if (rx_deliver && !rx_lost) begin
			rx_ready <= 1'b1; // R15
			rx_data_out <= rx_shift;
		end else if (rx_take_in) begin
			rx_ready <= 1'b0;
		end
	end
	assign rx_data_ready_out = rx_ready;
	// set beats a simultaneous software write
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			framing_flag <= 1'b0;
			overrun_flag <= 1'b0;
		end else begin
			framing_flag <= (wr_status ? reg_wdata_in[FRAMING_BIT] : framing_flag) | rx_bad_stop; // R12
			overrun_flag <= (wr_status ? reg_wdata_in[OVERRUN_BIT] : overrun_flag) | rx_lost; // R13
		end
	end

	// transmitter
	line_state_t tx_state;
	logic [2:0] tx_sub;
	logic [2:0] tx_bit;
	logic [7:0] tx_hold;
	logic [7:0] tx_shift;
	logic tx_hold_empty;
	wire tx_shift_empty = tx_state == LINE_IDLE;
	wire tx_move = link_enable && tx_shift_empty && !tx_hold_empty; // R17
	wire bit_end = tick && tx_sub == TICKS_PER_BIT_LAST;
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			tx_hold_empty <= 1'b1; // R14
			tx_hold <= '0;
		end else if (tx_load_in && tx_hold_empty) begin
			tx_hold_empty <= 1'b0;
			tx_hold <= tx_data_in;
		end else if (tx_move) begin
			tx_hold_empty <= 1'b1;
		end
	end
	assign tx_holding_empty_out = tx_hold_empty;
	always_ff @(posedge clock_in) begin
		if (reset_in || !link_enable) begin
			tx_state <= LINE_IDLE; // R14
			tx_sub <= '0;
			tx_bit <= '0;
			tx_shift <= '0;
			serial_tx_out <= 1'b1;
		end else begin
			unique case (tx_state)
				LINE_IDLE: begin
					serial_tx_out <= 1'b1;
					tx_sub <= '0;
					if (tx_move) begin
						tx_shift <= tx_hold;
						tx_state <= LINE_START;
						serial_tx_out <= 1'b0;
					end
				end
				LINE_START: if (tick) begin
					tx_sub <= tx_sub + 1'b1;
					if (bit_end) begin
						tx_state <= LINE_DATA;
						tx_bit <= '0;
						serial_tx_out <= tx_shift[0];
					end
				end
				LINE_DATA: if (tick) begin
					tx_sub <= tx_sub + 1'b1;
					if (bit_end) begin
						tx_bit <= tx_bit + 1'b1;
						tx_shift <= {1'b1, tx_shift[7:1]};
						serial_tx_out <= tx_bit == LAST_DATA_BIT ? 1'b1 : tx_shift[1];
						if (tx_bit == LAST_DATA_BIT) tx_state <= LINE_STOP;
					end
				end
				LINE_STOP: if (tick) begin
					tx_sub <= tx_sub + 1'b1;
					if (bit_end) tx_state <= LINE_IDLE;
				end
			endcase
		end
	end

	// interrupts: write one to clear, a new event wins over the clear
	logic [IRQ_WIDTH-1:0] irq_status;
	logic [IRQ_WIDTH-1:0] irq_mask;
	logic [IRQ_WIDTH-1:0] irq_events;
	assign irq_events[IRQ_RX_BIT] = rx_deliver && !rx_lost;
	assign irq_events[IRQ_FRAMING_BIT] = rx_bad_stop;
	assign irq_events[IRQ_OVERRUN_BIT] = rx_lost;
	assign irq_events[IRQ_BREAK_BIT] = any_hit;
	wire [IRQ_WIDTH-1:0] irq_clear = wr_irq_status ? reg_wdata_in[IRQ_WIDTH-1:0] : IRQ_RESET;
	wire [IRQ_WIDTH-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_events;
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			irq_status <= IRQ_RESET;
			irq_mask <= IRQ_RESET;
			irq_out <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			if (wr_irq_mask) irq_mask <= reg_wdata_in[IRQ_WIDTH-1:0];
			irq_out <= |(next_irq_status & (wr_irq_mask ? reg_wdata_in[IRQ_WIDTH-1:0] : irq_mask));
		end
	end

	// read mux; unmapped addresses read zero
	logic [31:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[FRAMING_BIT] = framing_flag; // R12
		status_word[OVERRUN_BIT] = overrun_flag; // R13
		status_word[TX_HOLD_EMPTY_BIT] = tx_hold_empty; // R14
		status_word[TX_SHIFT_EMPTY_BIT] = tx_shift_empty; // R14
		status_word[RX_READY_BIT] = rx_ready; // R15
	end
	wire [31:0] control_word = {30'h0000_0000, baud_locked, link_enable};
	wire [31:0] bp_one_addr_word = {bp_addr[0], 2'h0}; // R5
	wire [31:0] bp_two_addr_word = {bp_addr[1], 2'h0}; // R5
	wire [31:0] bp_one_mask_word = {bp_mask[0], bp_load_en[0], bp_write_en[0]};
	wire [31:0] bp_two_mask_word = {bp_mask[1], bp_load_en[1], bp_write_en[1]};
	wire [31:0] read_word =
		reg_addr_in == TIME_TAG_ADDR ? {2'h0, time_tag} : // R1
		reg_addr_in == BP_ONE_ADDR_ADDR ? bp_one_addr_word :
		reg_addr_in == BP_ONE_MASK_ADDR ? bp_one_mask_word :
		reg_addr_in == BP_TWO_ADDR_ADDR ? bp_two_addr_word :
		reg_addr_in == BP_TWO_MASK_ADDR ? bp_two_mask_word :
		reg_addr_in == LINK_STATUS_ADDR ? status_word :
		reg_addr_in == LINK_CONTROL_ADDR ? control_word :
		reg_addr_in == LINK_SCALER_ADDR ? {14'h0000, reload_value} : // R18
		reg_addr_in == IRQ_STATUS_ADDR ? {28'h000_0000, irq_status} :
		reg_addr_in == IRQ_MASK_ADDR ? {28'h000_0000, irq_mask} : 32'h0000_0000;
	wire [31:0] next_rdata = reg_read_in ? read_word : 32'h0000_0000;
	always_ff @(posedge clock_in) begin
		if (reset_in) reg_rdata_out <= 32'h0000_0000;
		else reg_rdata_out <= next_rdata;
	end
endmodule : debug_breakpoint_uart_regs

// *** test/debug_breakpoint_uart_regs_properties.sv ***
// concurrent checks on the ports of the breakpoint and debug link block
`timescale 1ns/1ps
module debug_breakpoint_uart_regs_properties
	import debug_link_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [31:0] reg_addr_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic debug_mode_in,
	input wire logic break_on_hw_breakpoint_in,
	input wire logic exec_valid_in,
	input wire logic bus_load_in,
	input wire logic bus_write_in,
	input wire logic breakpoint_hit_out,
	input wire logic debug_break_out,
	input wire logic [TIME_TAG_WIDTH-1:0] time_tag_out,
	input wire logic rx_data_ready_out,
	input wire logic tx_load_in,
	input wire logic tx_holding_empty_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	sequence load_taken;
		tx_load_in && tx_holding_empty_out;
	endsequence
	sequence holding_full;
		!tx_holding_empty_out;
	endsequence
	read_idle_zero_a: assert property (!reg_read_in |=> reg_rdata_out == 32'h0) else $error("read data not idle");
	tag_counts_a: assert property (!reset_in && !debug_mode_in && !reg_write_in |=>
		time_tag_out == $past(time_tag_out) + 30'h1) else $error("time tag did not advance");
	tag_holds_a: assert property (debug_mode_in && !reg_write_in |=> $stable(time_tag_out))
		else $error("time tag moved in debug mode");
	tag_read_view_a: assert property (reg_read_in && reg_addr_in == TIME_TAG_ADDR |=>
		reg_rdata_out == {2'h0, $past(time_tag_out)}) else $error("time tag read wrong");
	addr_low_zero_a: assert property (reg_read_in &&
		(reg_addr_in == BP_ONE_ADDR_ADDR || reg_addr_in == BP_TWO_ADDR_ADDR) |=> reg_rdata_out[1:0] == 2'h0)
		else $error("breakpoint address low bits not zero");
	scaler_upper_a: assert property (reg_read_in && reg_addr_in == LINK_SCALER_ADDR |=>
		reg_rdata_out[31:18] == 14'h0) else $error("scaler upper bits not zero");
	status_view_a: assert property (reg_read_in && reg_addr_in == LINK_STATUS_ADDR |=>
		reg_rdata_out[31:7] == 25'h0 && reg_rdata_out[5] == 1'b0
		&& reg_rdata_out[RX_READY_BIT] == $past(rx_data_ready_out)
		&& reg_rdata_out[TX_HOLD_EMPTY_BIT] == $past(tx_holding_empty_out)) else $error("status read wrong");
	break_gate_a: assert property (1'b1 |->
		debug_break_out == (breakpoint_hit_out && $past(break_on_hw_breakpoint_in))) else $error("break gating wrong");
	quiet_no_hit_a: assert property (!exec_valid_in && !bus_load_in && !bus_write_in |=> !breakpoint_hit_out)
		else $error("hit without access");
	holding_load_a: assert property (load_taken |=> holding_full) else $error("load not held");
endmodule : debug_breakpoint_uart_regs_properties
bind debug_breakpoint_uart_regs debug_breakpoint_uart_regs_properties checker_inst (.clock_in, .reset_in,
	.reg_addr_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .debug_mode_in, .break_on_hw_breakpoint_in,
	.exec_valid_in, .bus_load_in, .bus_write_in, .breakpoint_hit_out, .debug_break_out, .time_tag_out,
	.rx_data_ready_out, .tx_load_in, .tx_holding_empty_out);

// *** test/debug_host_model.sv ***
// debug host on the far end of the serial link
`timescale 1ns/1ps
module debug_host_model (
	input wire logic clock_in,
	input wire logic line_in,
	output logic line_out,
	output logic [7:0] got_out,
	output int got_cnt_out
);
	// reload 1 after lock, eight ticks of two clocks each
	localparam int BIT_CYCLES = 16;
	initial begin
		line_out = 1'b1;
		got_out = 8'h00;
		got_cnt_out = 0;
	end
	task automatic hold(input logic level, input int cycles);
		line_out <= level;
		repeat (cycles) @(posedge clock_in);
	endtask : hold
	task automatic send(input logic [7:0] data, input logic stop);
		hold(1'b0, BIT_CYCLES);
		for (int i = 0; i < 8; i++) hold(data[i], BIT_CYCLES);
		hold(stop, BIT_CYCLES);
		hold(1'b1, BIT_CYCLES);
	endtask : send
	// samples mid-bit, so a device rate off by up to half a clock per bit still lands
	always begin
		@(negedge line_in);
		repeat (BIT_CYCLES / 2) @(posedge clock_in);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clock_in);
			got_out[i] = line_in;
		end
		repeat (BIT_CYCLES) @(posedge clock_in);
		if (line_in === 1'b1) got_cnt_out = got_cnt_out + 1;
	end
endmodule : debug_host_model

// *** test/test_debug_breakpoint_uart_regs.sv ***
// testbench for the breakpoint, time tag and debug serial link block
`timescale 1ns/1ps
module test_debug_breakpoint_uart_regs
	import debug_link_pkg::*;
;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic [31:0] reg_addr_in = 32'h0, reg_wdata_in = 32'h0, exec_addr_in = 32'h0, bus_addr_in = 32'h0;
	logic reg_write_in = 1'b0, reg_read_in = 1'b0, debug_mode_in = 1'b0, break_on_hw_breakpoint_in = 1'b0;
	logic exec_valid_in = 1'b0, bus_load_in = 1'b0, bus_write_in = 1'b0, rx_take_in = 1'b0, tx_load_in = 1'b0;
	logic [7:0] tx_data_in = 8'h00;
	logic [7:0] rx_data_out, got;
	logic [31:0] reg_rdata_out, v, a;
	logic breakpoint_hit_out, debug_break_out, serial_rx_in, serial_tx_out, rx_data_ready_out;
	logic tx_holding_empty_out, irq_out;
	logic [TIME_TAG_WIDTH-1:0] time_tag_out;
	int error_cnt = 0, checks_done = 0, got_cnt;
	always #50 clock_in = ~clock_in;
	debug_breakpoint_uart_regs DUT (.clock_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
		.reg_read_in, .reg_rdata_out, .debug_mode_in, .break_on_hw_breakpoint_in, .exec_valid_in, .exec_addr_in,
		.bus_load_in, .bus_write_in, .bus_addr_in, .breakpoint_hit_out, .debug_break_out, .time_tag_out,
		.serial_rx_in, .serial_tx_out, .rx_data_out, .rx_data_ready_out, .rx_take_in, .tx_data_in, .tx_load_in,
		.tx_holding_empty_out, .irq_out);
	debug_host_model host (.clock_in, .line_in(serial_tx_out), .line_out(serial_rx_in), .got_out(got),
		.got_cnt_out(got_cnt));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [31:0] addr, input logic [31:0] data);
		@(posedge clock_in);
		reg_addr_in <= addr;
		reg_wdata_in <= data;
		reg_write_in <= 1'b1;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [31:0] addr);
		@(posedge clock_in);
		reg_addr_in <= addr;
		reg_read_in <= 1'b1;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask : rd
	task automatic hit(input logic [2:0] kind, input logic [31:0] addr, input logic eh, input logic eb);
		@(posedge clock_in);
		{exec_valid_in, bus_load_in, bus_write_in} <= kind;
		exec_addr_in <= addr;
		bus_addr_in <= addr;
		@(posedge clock_in);
		{exec_valid_in, bus_load_in, bus_write_in} <= 3'h0;
		#1 chk("hit", {31'h0, eh}, {31'h0, breakpoint_hit_out});
		chk("break", {31'h0, eb}, {31'h0, debug_break_out});
	endtask : hit
	task automatic take();
		@(posedge clock_in);
		rx_take_in <= 1'b1;
		@(posedge clock_in);
		rx_take_in <= 1'b0;
	endtask : take
	task automatic load(input logic [7:0] data);
		@(posedge clock_in);
		tx_data_in <= data;
		tx_load_in <= 1'b1;
		@(posedge clock_in);
		tx_load_in <= 1'b0;
	endtask : load
	task automatic wait_got(input int n, input logic [7:0] exp);
		for (int i = 0; i < 400 && got_cnt < n; i++) @(posedge clock_in);
		chk("host count", n, got_cnt);
		chk("host byte", {24'h0, exp}, {24'h0, got});
	endtask : wait_got
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20000) @(posedge clock_in);
		error_cnt++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clock_in);
		reset_in <= 1'b0;
		rd(LINK_STATUS_ADDR);
		chk("status", 32'h6, v);
		rd(LINK_CONTROL_ADDR);
		chk("control", 32'h0, v);
		rd(LINK_SCALER_ADDR);
		chk("scaler", 32'h3_FFFF, v);
		wr(LINK_SCALER_ADDR, 32'hFFFD_5A5A);
		rd(LINK_SCALER_ADDR);
		chk("scaler", 32'h1_5A5A, v);
		rd(32'h8000_00F0);
		chk("unmapped", 32'h0, v);
		hit(3'h7, 32'h0, 1'b0, 1'b0);
		$display("test registers done");
		debug_mode_in <= 1'b1;
		wr(TIME_TAG_ADDR, 32'hFFFF_FFFF);
		rd(TIME_TAG_ADDR);
		chk("time tag", 32'h3FFF_FFFF, v);
		debug_mode_in <= 1'b0;
		repeat (10) @(posedge clock_in);
		// wraps through zero on the way
		#1 chk("time tag", 32'h9, {2'h0, time_tag_out});
		$display("test time tag done");
		for (int i = 0; i < 2; i++) begin
			a = i ? 32'h8765_4300 : 32'h1234_5600;
			wr(BP_ONE_ADDR_ADDR + 8 * i, a | 32'h3);
			wr(BP_ONE_MASK_ADDR + 8 * i, 32'hFFFF_FF03);
			rd(BP_ONE_ADDR_ADDR + 8 * i);
			chk("bp address", a, v);
			rd(BP_ONE_MASK_ADDR + 8 * i);
			chk("bp mask", 32'hFFFF_FF03, v);
			break_on_hw_breakpoint_in <= 1'b1;
			hit(3'h4, a + 32'h3C, 1'b1, 1'b1);
			hit(3'h2, a ^ 32'h100, 1'b0, 1'b0);
			hit(3'h1, a + 32'h4, 1'b1, 1'b1);
			break_on_hw_breakpoint_in <= 1'b0;
			hit(3'h2, a, 1'b1, 1'b0);
			wr(BP_ONE_ADDR_ADDR + 8 * i, a);
			wr(BP_ONE_MASK_ADDR + 8 * i, 32'hFFFF_FF00);
			hit(3'h7, a, 1'b0, 1'b0);
		end
		$display("test breakpoints done");
		wr(LINK_CONTROL_ADDR, 32'h1);
		host.hold(1'b0, 20);
		host.hold(1'b1, 40);
		rd(LINK_CONTROL_ADDR);
		chk("control", 32'h3, v);
		rd(LINK_SCALER_ADDR);
		chk("measured reload", 32'h1, v);
		take();
		host.send(8'hA3, 1'b1);
		chk("rx data", 32'hA3, {24'h0, rx_data_out});
		host.send(8'h3C, 1'b1);
		rd(LINK_STATUS_ADDR);
		chk("status", 32'h17, v);
		chk("rx data", 32'hA3, {24'h0, rx_data_out});
		wr(LINK_STATUS_ADDR, 32'h0);
		take();
		host.send(8'h96, 1'b0);
		// a bad stop may be taken for a new start, so ready is not judged
		rd(LINK_STATUS_ADDR);
		chk("status", 32'h46, v & 32'hFFFF_FFFE);
		wr(LINK_STATUS_ADDR, 32'h0);
		rd(LINK_STATUS_ADDR);
		chk("status", 32'h6, v & 32'hFFFF_FFFE);
		load(8'h5A);
		repeat (3) @(posedge clock_in);
		load(8'hC3);
		repeat (3) @(posedge clock_in);
		load(8'hE1);
		wait_got(1, 8'h5A);
		wait_got(2, 8'hC3);
		repeat (200) @(posedge clock_in);
		wait_got(2, 8'hC3);
		rd(LINK_STATUS_ADDR);
		chk("status", 32'h6, v & 32'h6);
		$display("test serial done");
		rd(IRQ_STATUS_ADDR);
		chk("irq status", 32'hF, v);
		chk("irq", 32'h0, {31'h0, irq_out});
		wr(IRQ_MASK_ADDR, 32'h8);
		#1 chk("irq", 32'h1, {31'h0, irq_out});
		wr(IRQ_STATUS_ADDR, 32'h8);
		#1 chk("irq", 32'h0, {31'h0, irq_out});
		rd(IRQ_STATUS_ADDR);
		chk("irq status", 32'h7, v);
		$display("test interrupt done");
		wrap_up();
	end
endmodule : test_debug_breakpoint_uart_regs
